// [hdl/input_router_pkg.sv]
package input_router_pkg;

    localparam int TERM_COUNT = 7;
    localparam int CODE_W = 4;
    localparam int SEL_W = 16;

    // Field positions within the selection word
    localparam int REV_INHIBIT_LSB = 0;
    localparam int RESERVED_LSB = 4;
    localparam int FWD_LIMIT_LSB = 8;
    localparam int REV_LIMIT_LSB = 12;

    localparam logic [SEL_W-1:0] SEL_RESET = 16'h8882;
    localparam logic [SEL_W-1:0] SEL_RW_MASK = 16'hFFFF;

    // Code table shared by all three fields
    localparam logic [CODE_W-1:0] CODE_CLOSED_MAX = 4'h6;
    localparam logic [CODE_W-1:0] CODE_FORCE_ON = 4'h7;
    localparam logic [CODE_W-1:0] CODE_FORCE_OFF = 4'h8;
    localparam logic [CODE_W-1:0] CODE_OPEN_BASE = 4'h9;

    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_SEL_PENDING = 8'h00;
    localparam logic [7:0] ADDR_SEL_ACTIVE = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam int CTRL_RESTART_BIT = 0;

endpackage

// [hdl/reverse_limit_input_router.sv]
`timescale 1ns/100ps

// What this block does
// - Reverse inhibit codes 0-6 permit on closed terminal; 9-F permit on open.
// - Reverse inhibit code 8 always permits reverse travel; code 7 always prohibits.
// - Forward limit codes 0-6 assert on closed; 7 forced on; 8 forced off.
// - Forward limit codes 9-F assert while the chosen terminal is open.
// - Reverse limit uses the top field with the forward limit code table.
module reverse_limit_input_router #(
    parameter int TERMS = input_router_pkg::TERM_COUNT
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Terminal levels, high means closed; index 0 is the first listed terminal
    input wire logic [TERMS-1:0] term_closed,
    output logic reverse_permit,
    output logic fwd_external_torque_limit,
    output logic rev_external_torque_limit
);

    typedef logic [input_router_pkg::CODE_W-1:0] code_t;

    // Decoder slots, one per routed signal
    localparam int FIELDS = 3;
    localparam int SLOT_REV_INHIBIT = 0;
    localparam int SLOT_FWD_LIMIT = 1;
    localparam int SLOT_REV_LIMIT = 2;

    logic [TERMS-1:0] term_meta_r;
    logic [TERMS-1:0] term_sync_r;
    logic [input_router_pkg::SEL_W-1:0] input_select_reverse_limits_r;
    logic [input_router_pkg::SEL_W-1:0] sel_active_r;
    logic restart_r;
    logic restart_nxt;
    logic setup_ok;
    logic wr_access;
    logic rd_access;
    logic hit_pending;
    logic hit_active;
    logic hit_control;
    logic hit_status;
    logic addr_ok;
    logic pending_we;
    logic [31:0] rdata_nxt;
    logic reverse_permit_nxt;
    code_t field_code [FIELDS];
    logic field_level [FIELDS];

    ////////////////////////////////////////////////////////////////////////////
    // Terminal synchronisers

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            term_meta_r <= '0;
            term_sync_r <= '0;
        end
        else
        begin
            term_meta_r <= term_closed;
            term_sync_r <= term_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: pready answers in the first access cycle, no wait states

    assign hit_pending = (paddr == input_router_pkg::ADDR_SEL_PENDING);
    assign hit_active = (paddr == input_router_pkg::ADDR_SEL_ACTIVE);
    assign hit_control = (paddr == input_router_pkg::ADDR_CONTROL);
    assign hit_status = (paddr == input_router_pkg::ADDR_STATUS);
    assign addr_ok = hit_pending || hit_active || hit_control || hit_status;

    assign setup_ok = psel && !penable;
    // Writes land only at the edge that closes the access phase
    assign wr_access = psel && penable && pwrite && pready;
    assign rd_access = setup_ok && !pwrite;
    assign pending_we = wr_access && hit_pending;
    assign restart_nxt = wr_access && hit_control && pwdata[input_router_pkg::CTRL_RESTART_BIT];

    // Ready follows setup by one edge, so it pulses once per transfer
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup_ok;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= setup_ok && !addr_ok;
        end
    end

    // Control reads back as zero: restart is a strobe, not a stored bit
    always_comb
    begin
        rdata_nxt = '0;
        if (hit_pending)
            rdata_nxt = 32'(input_select_reverse_limits_r);
        else if (hit_active)
            rdata_nxt = 32'(sel_active_r);
        else if (hit_status)
            rdata_nxt = {29'h0, rev_external_torque_limit, fwd_external_torque_limit,
                reverse_permit};
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prdata <= '0;
        end
        else if (rd_access)
        begin
            prdata <= rdata_nxt;
        end
    end

    // The pending copy is what software edits; it drives nothing until restart
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            input_select_reverse_limits_r <= input_router_pkg::SEL_RESET;
        end
        else if (pending_we)
        begin
            input_select_reverse_limits_r <= pwdata[input_router_pkg::SEL_W-1:0]
                & input_router_pkg::SEL_RW_MASK;
        end
    end

    // Restart strobe: self-clearing so it acts once per write
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            restart_r <= 1'b0;
        end
        else
        begin
            restart_r <= restart_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active selection, loaded only at reset or restart

    // A mid-run write cannot glitch routing; the cost is one restart per change
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sel_active_r <= input_router_pkg::SEL_RESET;
        end
        else if (restart_r)
        begin
            sel_active_r <= input_select_reverse_limits_r;
        end
    end

    assign field_code[SLOT_REV_INHIBIT] =
        sel_active_r[input_router_pkg::REV_INHIBIT_LSB +: input_router_pkg::CODE_W];
    assign field_code[SLOT_FWD_LIMIT] =
        sel_active_r[input_router_pkg::FWD_LIMIT_LSB +: input_router_pkg::CODE_W];
    assign field_code[SLOT_REV_LIMIT] =
        sel_active_r[input_router_pkg::REV_LIMIT_LSB +: input_router_pkg::CODE_W];

    ////////////////////////////////////////////////////////////////////////////
    // Field decoders, one per routed signal, sharing one code table

    for (genvar f = 0; f < FIELDS; f++)
    begin : g_decode
        always_comb
        begin
            field_level[f] = 1'b0;
            if (field_code[f] <= input_router_pkg::CODE_CLOSED_MAX)
            begin
                field_level[f] = term_sync_r[field_code[f][2:0]];
            end
            else if (field_code[f] == input_router_pkg::CODE_FORCE_ON)
            begin
                field_level[f] = 1'b1;
            end
            else if (field_code[f] == input_router_pkg::CODE_FORCE_OFF)
            begin
                field_level[f] = 1'b0;
            end
            else
            begin
                // Open-contact codes reuse the closed-contact order, inverted
                field_level[f] =
                    ~term_sync_r[3'(field_code[f] - input_router_pkg::CODE_OPEN_BASE)];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routed outputs, registered

    // Code 7 decodes as forced on, but for travel it means prohibit
    always_comb
    begin
        if (field_code[SLOT_REV_INHIBIT] == input_router_pkg::CODE_FORCE_ON)
        begin
            reverse_permit_nxt = 1'b0;
        end
        else if (field_code[SLOT_REV_INHIBIT] == input_router_pkg::CODE_FORCE_OFF)
        begin
            reverse_permit_nxt = 1'b1;
        end
        else
        begin
            reverse_permit_nxt = field_level[SLOT_REV_INHIBIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            reverse_permit <= 1'b0;
        end
        else
        begin
            reverse_permit <= reverse_permit_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            fwd_external_torque_limit <= 1'b0;
        end
        else
        begin
            fwd_external_torque_limit <= field_level[SLOT_FWD_LIMIT];
        end
    end

    // Same table as the forward limit, only the field differs
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rev_external_torque_limit <= 1'b0;
        end
        else
        begin
            rev_external_torque_limit <= field_level[SLOT_REV_LIMIT];
        end
    end

endmodule

// [tb/router_checker.sv]
`timescale 1ns/100ps
module router_checker #(parameter int TERMS = 7) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [TERMS-1:0] term_closed,
    input wire logic reverse_permit
);
    default clocking @(posedge clk); endclocking
    // No restart access and quiet contacts long enough for every stage to settle
    sequence calm_s;
        (!(psel && paddr == 8'h08) && $stable(term_closed))[*5];
    endsequence
    answer_once_a: assert property (disable iff (!nrst) psel && !penable |=> pready)
        else $error("no answer");
    ready_pulse_a: assert property (disable iff (!nrst) pready |=> !pready)
        else $error("ready too long");
    err_unmapped_a: assert property (disable iff (!nrst)
        psel && !penable && paddr > 8'h0C |=> pslverr) else $error("no error");
    err_alone_a: assert property (disable iff (!nrst) pslverr |-> pready)
        else $error("stray error");
    reset_quiet_a: assert property (!nrst |=> !pready && !reverse_permit)
        else $error("active in reset");
    route_hold_a: assert property (disable iff (!nrst) calm_s |-> $stable(reverse_permit))
        else $error("routing moved");
endmodule
bind reverse_limit_input_router router_checker #(.TERMS(TERMS)) chk (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .term_closed(term_closed), .reverse_permit(reverse_permit));

// [tb/limit_switch_model.sv]
`timescale 1ns/100ps
// Contacts follow the bench a clock later; bounce is not modelled
module limit_switch_model (
    input wire logic clk,
    input wire logic [6:0] want,
    output logic [6:0] term_closed
);
    always_ff @(posedge clk)
        term_closed <= want;
endmodule

// [tb/test_reverse_limit_input_router.sv]
`timescale 1ns/100ps
module test_reverse_limit_input_router;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rp, fl, rl;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [6:0] want = 7'h00, term;
    int error_cnt = 0, n_tests = 0;
    initial forever #2 clk = ~clk;
    limit_switch_model sw (.clk(clk), .want(want), .term_closed(term));
    reverse_limit_input_router dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term_closed(term), .reverse_permit(rp),
        .fwd_external_torque_limit(fl), .rev_external_torque_limit(rl));
    ////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Request stands until the edge at which pready is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge clk);
            i++;
        end
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20)
        begin
            error_cnt++;
            results();
        end
    endtask
    // Codes 7 and 8 force opposite levels for the permit and for the limits
    function automatic logic hit(input logic [3:0] k, input logic p);
        if (k == 4'h7)
            return !p;
        if (k == 4'h8)
            return p;
        return k < 4'h7 ? want[k] : !want[k - 4'h9];
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic e;
        logic [15:0] s;
        logic [31:0] x;
        repeat (5) @(posedge clk);
        nrst <= 1;
        xfer(0, 8'h00, 0, e);
        chk(rd, 32'h8882);
        xfer(0, 8'h10, 0, e);
        chk(e, 1);
        xfer(1, 8'h00, 32'h7777, e);
        repeat (6) @(posedge clk);
        xfer(0, 8'h04, 0, e);
        chk(rd, 32'h8882);
        chk({rl, fl}, 0);
        for (int c = 0; c < 16; c++)
        begin
            s = {c[3:0], c[3:0] + 4'h1, c[3:0], c[3:0] + 4'h2};
            xfer(1, 8'h00, {16'h0, s}, e);
            xfer(1, 8'h08, 32'h1, e);
            for (int p = 0; p < 2; p++)
            begin
                want <= p ? 7'h2A : 7'h55;
                repeat (6) @(posedge clk);
                x = {29'h0, hit(s[15:12], 0), hit(s[11:8], 0), hit(s[3:0], 1)};
                xfer(0, 8'h0C, 0, e);
                chk(rd, x);
                chk({rl, fl, rp}, x);
            end
        end
        // A reset in mid-run reloads the default selection
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        repeat (6) @(posedge clk);
        xfer(0, 8'h04, 0, e);
        chk(rd, 32'h8882);
        chk({rl, fl}, 0);
        results();
    end
endmodule
